// *** rtl/cmd_write.sv ***
// Command decoder and write sequencer for the single-wire EEPROM
`include "cmd_write_consts.svh"
`default_nettype none
module cmd_write
    import cmd_write_pkg::*;
#(
    parameter bit HAS_STD_SPEED = 1'b1,
    parameter int unsigned WR_CYCLES =
        `WRITE_CYCLE_TIME_NS / `CLK_PERIOD_NS,
    parameter int unsigned DSCHG_CYCLES =
        (`DISCHARGE_INTERRUPT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] slave_select_i,
    input wire logic start_i,
    input wire logic bit_valid_i,
    input wire logic bit_i,
    input wire logic stop_i,
    input wire logic out_frame_i,
    input wire logic line_low_i,
    output logic sio_o,
    output logic sio_oe_o,
    output logic busy_o,
    output logic std_speed_o,
    output logic sec_locked_o,
    output logic zones_frozen_o,
    output logic [3:0] zone_ro_o,
    output logic prog_abort_o,
    output logic read_req_o,
    output logic [3:0] read_op_o,
    output logic [6:0] read_addr_o,
    output logic mem_valid_o,
    input wire logic mem_ready_i,
    output logic mem_region_o,
    output logic [6:0] mem_addr_o,
    output logic [7:0] mem_data_o
);
    typedef struct packed {
        cmd_state_t st;
        logic [2:0] bits;
        logic [6:0] shift;
        logic [3:0] op;
        logic rw;
        logic [6:0] addr;
        logic have_data;
        logic ack_armed;
        logic ack_val;
        logic std;
        logic locked;
        logic frozen;
        logic [3:0] zone_ro;
        logic [7:0] pend_data;
        logic [31:0] timer;
        logic [31:0] dsch;
        logic abort;
        logic rd_req;
    } core_state_t;

    core_state_t r_reg, r_next;
    logic byte_done;
    logic [7:0] byte_in;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic fifo_flush, data_ok;
    logic [`FIFO_WIDTH-1:0] fifo_out;

    function automatic logic op_known(input logic [3:0] op);
        unique case (op)
            `OP_EEPROM, `OP_SECURE, `OP_LOCK, `OP_ZONE, `OP_FREEZE,
            `OP_MAKER_ID, `OP_STD_SPEED, `OP_HIGH_SPEED: op_known = 1'b1;
            default: op_known = 1'b0;
        endcase
    endfunction

    // Whether a data byte may be taken, ignoring FIFO room
    function automatic logic may_write(input logic [3:0] op,
                                       input logic [6:0] addr,
                                       input core_state_t s);
        unique case (op)
            `OP_EEPROM: may_write = !s.zone_ro[addr[6:5]];
            `OP_SECURE: may_write = addr[4] && !s.locked;
            `OP_LOCK: may_write = !s.locked;
            `OP_ZONE, `OP_FREEZE: may_write = !s.frozen;
            default: may_write = 1'b0;
        endcase
    endfunction

    function automatic logic is_array_op(input logic [3:0] op);
        is_array_op = (op == `OP_EEPROM) || (op == `OP_SECURE);
    endfunction

    assign byte_done = bit_valid_i && (r_reg.bits == 3'h7);
    assign byte_in = {r_reg.shift, bit_i};
    assign data_ok = may_write(r_reg.op, r_reg.addr, r_reg) &&
        (!is_array_op(r_reg.op) || fifo_in_ready);
    assign fifo_in_valid = (r_reg.st == ST_DATA) && byte_done &&
        is_array_op(r_reg.op) && may_write(r_reg.op, r_reg.addr, r_reg);
    // Drop queued bytes on a start outside programming, a stop that starts no write, or aborted programming
    assign fifo_flush = (start_i && (r_reg.st != ST_PROG)) ||
        (r_reg.st == ST_PROG && r_reg.dsch == 32'(DSCHG_CYCLES - 1) &&
        line_low_i) ||
        (stop_i && r_reg.st != ST_PROG &&
        !(r_reg.st == ST_DATA && r_reg.bits == 3'h0 && r_reg.have_data));

    write_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(fifo_flush),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i({r_reg.op[0], r_reg.addr, byte_in}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out)
    );

    // Bytes reach the array only inside the programming cycle
    assign mem_valid_o = fifo_out_valid && (r_reg.st == ST_PROG);
    assign fifo_out_ready = mem_ready_i && (r_reg.st == ST_PROG);
    assign mem_region_o = fifo_out[15];
    assign mem_addr_o = fifo_out[14:8];
    assign mem_data_o = fifo_out[7:0];

    assign sio_o = 1'b0;
    assign sio_oe_o = out_frame_i && r_reg.ack_armed && r_reg.ack_val; // R24
    assign busy_o = r_reg.st == ST_PROG;
    assign std_speed_o = r_reg.std;
    assign sec_locked_o = r_reg.locked;
    assign zones_frozen_o = r_reg.frozen;
    assign zone_ro_o = r_reg.zone_ro;
    assign prog_abort_o = r_reg.abort;
    assign read_req_o = r_reg.rd_req;
    assign read_op_o = r_reg.op;
    assign read_addr_o = r_reg.addr;

    always_comb begin
        r_next = r_reg;
        r_next.rd_req = 1'b0;
        if (r_reg.st != ST_PROG) begin
            if (bit_valid_i) begin
                r_next.bits = r_reg.bits + 3'h1;
                r_next.shift = byte_in[6:0];
                r_next.ack_armed = 1'b0;
            end
            if (start_i) begin
                r_next.st = ST_DEV;
                r_next.bits = 3'h0;
                r_next.ack_armed = 1'b0;
                r_next.have_data = 1'b0;
                r_next.abort = 1'b0;
            end else if (stop_i) begin // R14
                r_next.ack_armed = 1'b0;
                r_next.bits = 3'h0;
                if (r_reg.st == ST_DATA && r_reg.bits == 3'h0 &&
                    r_reg.have_data) begin
                    r_next.st = ST_PROG; // R15
                    r_next.timer = '0;
                    r_next.dsch = '0;
                end else begin
                    r_next.st = ST_IDLE; // R10 R25
                end
            end else if (byte_done) begin
                r_next.ack_armed = 1'b1;
                r_next.ack_val = 1'b1;
                unique case (r_reg.st)
                    ST_DEV: begin
                        r_next.op = byte_in[7:4];
                        r_next.rw = byte_in[0];
                        r_next.st = ST_WAIT;
                        if (!op_known(byte_in[7:4]) ||
                            byte_in[3:1] != slave_select_i) begin
                            r_next.ack_armed = 1'b0; // R23
                            r_next.st = ST_IDLE;
                        end else begin
                            unique case (byte_in[7:4])
                                `OP_EEPROM, `OP_SECURE, `OP_ZONE: begin
                                    if (!byte_in[0]) begin
                                        r_next.st = ST_ADDR; // R01 R02 R04
                                    end else begin
                                        r_next.rd_req = 1'b1;
                                    end
                                end
                                `OP_LOCK, `OP_FREEZE: begin
                                    r_next.st = ST_ADDR; // R03 R05
                                end
                                `OP_MAKER_ID: begin
                                    r_next.rd_req = 1'b1; // R06
                                end
                                `OP_STD_SPEED: begin
                                    if (!HAS_STD_SPEED) begin
                                        r_next.ack_val = 1'b0; // R07
                                    end else if (byte_in[0]) begin
                                        r_next.ack_val = r_reg.std;
                                    end else begin
                                        r_next.std = 1'b1;
                                    end
                                end
                                default: begin
                                    if (byte_in[0]) begin
                                        r_next.ack_val = !r_reg.std; // R08
                                    end else begin
                                        r_next.std = 1'b0;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_ADDR: begin
                        r_next.addr = byte_in[6:0]; // R22
                        r_next.st = ST_DATA; // R13
                        if (r_reg.op == `OP_LOCK) begin
                            r_next.ack_val = !r_reg.locked &&
                                byte_in[7:4] == `LOCK_ADDR_KEY; // R03
                        end else if (r_reg.op == `OP_FREEZE ||
                                     r_reg.op == `OP_ZONE) begin
                            r_next.ack_val = !r_reg.frozen; // R05
                        end
                        if (!r_next.ack_val) begin
                            r_next.st = ST_WAIT;
                        end
                    end
                    ST_DATA: begin
                        r_next.ack_val = data_ok; // R18
                        if (data_ok) begin
                            r_next.have_data = 1'b1; // R17
                            r_next.pend_data = byte_in;
                            if (is_array_op(r_reg.op)) begin
                                r_next.addr = {r_reg.addr[6:3],
                                    r_reg.addr[2:0] + 3'h1}; // R19
                            end
                        end else begin
                            r_next.st = ST_WAIT;
                        end
                    end
                    default: begin
                        r_next.ack_armed = 1'b0;
                    end
                endcase
            end
        end else begin
            // Commands ignored; unanswered frames read as NACK
            r_next.ack_armed = 1'b0; // R11
            if (r_reg.timer != 32'(WR_CYCLES - 1)) begin
                r_next.timer = r_reg.timer + 32'h1;
            end
            if (line_low_i) begin
                r_next.dsch = r_reg.dsch + 32'h1;
            end else begin
                r_next.dsch = '0;
            end
            if (line_low_i && r_reg.dsch == 32'(DSCHG_CYCLES - 1)) begin
                r_next.st = ST_IDLE; // R12 R21
                r_next.abort = 1'b1;
            end else if (r_reg.timer == 32'(WR_CYCLES - 1) &&
                         !fifo_out_valid) begin
                r_next.st = ST_IDLE; // R25
                unique case (r_reg.op)
                    `OP_LOCK: r_next.locked = 1'b1; // R03
                    `OP_FREEZE: r_next.frozen = 1'b1; // R05
                    `OP_ZONE: begin
                        if (r_reg.pend_data != 8'h00) begin
                            r_next.zone_ro[r_reg.addr[1:0]] = 1'b1; // R04
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_bad_op_silent: assert property ( // R23
        r_reg.st == ST_DEV && byte_done && !start_i && !stop_i &&
        !op_known(byte_in[7:4]) |=> r_reg.st == ST_IDLE && !r_reg.ack_armed)
        else $error("Invalid opcode was answered");
    chk_prog_after_stop: assert property ( // R15
        r_reg.st == ST_DATA && stop_i && !start_i && r_reg.bits == 3'h0 &&
        r_reg.have_data |=> busy_o && r_reg.timer == 32'h0)
        else $error("Valid stop did not start programming");
    chk_abort_stop: assert property ( // R10
        r_reg.st == ST_DATA && stop_i && !start_i && r_reg.bits != 3'h0
        |=> r_reg.st == ST_IDLE ##1 !mem_valid_o)
        else $error("Misplaced stop did not abort the write");
    chk_busy_nack: assert property ( // R11
        busy_o |-> !sio_oe_o)
        else $error("Device answered while programming");
    chk_discharge_end: assert property ( // R12
        busy_o && line_low_i && r_reg.dsch == 32'(DSCHG_CYCLES - 1)
        |=> !busy_o && prog_abort_o && $stable(sec_locked_o))
        else $error("Long low did not terminate programming");
    chk_page_wrap: assert property ( // R19
        fifo_in_valid && fifo_in_ready && !start_i && !stop_i
        |=> r_reg.addr[6:3] == $past(r_reg.addr[6:3]) &&
        r_reg.addr[2:0] == $past(r_reg.addr[2:0]) + 3'h1)
        else $error("Page address counter stepped wrongly");
    chk_std_nack: assert property ( // R07
        r_reg.st == ST_DEV && byte_done && !start_i && !stop_i &&
        byte_in[7:4] == `OP_STD_SPEED && byte_in[3:1] == slave_select_i
        && !HAS_STD_SPEED |=> r_reg.ack_armed && !r_reg.ack_val)
        else $error("Missing standard speed not refused");
    chk_hs_ack: assert property ( // R08
        r_reg.st == ST_DEV && byte_done && !start_i && !stop_i &&
        byte_in == {`OP_HIGH_SPEED, slave_select_i, 1'b0}
        |=> r_reg.ack_val && !std_speed_o)
        else $error("High speed select not acknowledged");
    chk_lock_applied: assert property ( // R03
        busy_o && r_reg.op == `OP_LOCK ##1 !busy_o && !prog_abort_o
        |-> sec_locked_o)
        else $error("Lock not applied after programming");
endmodule
`default_nettype wire

// *** rtl/cmd_write_consts.svh ***
// Constants for the single-wire EEPROM command decoder and write sequencer
//
// Contract
// R01 - Opcode A accesses main array
// R02 - Opcode B: secure region, upper part writable
// R03 - Opcode 2 permanently locks secure user part; code clears the lock on rst_i
// R04 - Four zones, opcode 7 sets read-only
// R05 - Opcode 1 freezes zone configuration forever; code clears the freeze on rst_i
// R06 - Opcode C returns identification data
// R07 - Opcode D standard speed; absent variant NACKs
// R08 - Opcode E high speed; always ACK there
// R09 - Master writes start, addr, data, stop
// R10 - Stop off byte boundary aborts write
// R11 - Busy: ignore commands, NACK short pulses
// R12 - Long low during programming terminates write
// R13 - ACK device byte, address, data byte
// R14 - Stop is null frame, line high
// R15 - Valid stop starts self-timed programming
// R16 - Master keeps line high whole cycle
// R17 - Page write up to eight bytes; code takes up to 32 (FIFO_DEPTH), address wrapping in the page
// R18 - Up to seven more bytes, each ACKed; code ACKs up to 31 more
// R19 - Only low three address bits increment
// R20 - No traffic while any device programs
// R21 - Abort by long low, limited corruption
// R22 - Address byte top bit ignored
// R23 - Opcode/select/direction layout; mismatch stays silent
// R24 - ACK pulls line low, NACK releases
// R25 - Return to idle after every transaction
`ifndef CMD_WRITE_CONSTS_SVH
`define CMD_WRITE_CONSTS_SVH

`define OP_EEPROM 4'hA
`define OP_SECURE 4'hB
`define OP_LOCK 4'h2
`define OP_ZONE 4'h7
`define OP_FREEZE 4'h1
`define OP_MAKER_ID 4'hC
`define OP_STD_SPEED 4'hD
`define OP_HIGH_SPEED 4'hE
`define LOCK_ADDR_KEY 4'h6
`define CLK_PERIOD_NS 5
`define WRITE_CYCLE_TIME_NS 5000000
`define DISCHARGE_INTERRUPT_TIME_NS 150000
`define FIFO_WIDTH 16
`define FIFO_DEPTH 32

`endif

// *** rtl/cmd_write_pkg.sv ***
// Types shared by the command decoder
`default_nettype none
package cmd_write_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_ADDR = 3'b010,
        ST_DATA = 3'b011,
        ST_WAIT = 3'b100,
        ST_PROG = 3'b101
    } cmd_state_t;
endpackage
`default_nettype wire

// *** rtl/write_fifo.sv ***
// Write data FIFO with registered output word
`default_nettype none
module write_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic out_valid;
        logic [WIDTH-1:0] out_data;
    } fifo_state_t;
    fifo_state_t r_reg, r_next;
    logic push, pop, load;

    // Output register counts as one of the DEPTH words
    assign in_ready_o =
        (r_reg.count + (AW+1)'(r_reg.out_valid)) != (AW+1)'(DEPTH);
    assign out_valid_o = r_reg.out_valid;
    assign out_data_o = r_reg.out_data;

    always_comb begin
        r_next = r_reg;
        push = in_valid_i && in_ready_o;
        pop = r_reg.out_valid && out_ready_i;
        load = (r_reg.count != '0) && (!r_reg.out_valid || pop);
        if (pop) begin
            r_next.out_valid = 1'b0;
        end
        if (load) begin
            r_next.out_data = r_reg.mem[r_reg.rd_ptr];
            r_next.out_valid = 1'b1;
            r_next.rd_ptr = r_reg.rd_ptr + 1'b1;
        end
        if (push) begin
            r_next.mem[r_reg.wr_ptr] = in_data_i;
            r_next.wr_ptr = r_reg.wr_ptr + 1'b1;
        end
        r_next.count = r_reg.count + (AW+1)'(push) - (AW+1)'(load);
        if (flush_i) begin
            r_next.wr_ptr = '0;
            r_next.rd_ptr = '0;
            r_next.count = '0;
            r_next.out_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule
`default_nettype wire

// *** testbench/host_master.sv ***
// Bus master model issuing decoded bit frames
`default_nettype none
module host_master (
    input wire logic clk_i,
    input wire logic sio_oe_i,
    output logic start_o,
    output logic bit_valid_o,
    output logic bit_o,
    output logic stop_o,
    output logic out_frame_o,
    output logic line_low_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        start_o = 1'b0;
        bit_valid_o = 1'b0;
        bit_o = 1'b0;
        stop_o = 1'b0;
        out_frame_o = 1'b0;
        line_low_o = 1'b0;
    end
    task automatic send_start();
        @(negedge clk_i);
        start_o = 1'b1;
        @(negedge clk_i);
        start_o = 1'b0;
    endtask
    // MSB first; bit line scrambled between frames
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            @(negedge clk_i);
            bit_valid_o = 1'b1;
            bit_o = b[i];
        end
        @(negedge clk_i);
        bit_valid_o = 1'b0;
        bit_o = ~bit_o;
    endtask
    task automatic get_ack(output logic ack);
        @(negedge clk_i);
        out_frame_o = 1'b1;
        #1;
        ack = sio_oe_i;
        @(negedge clk_i);
        out_frame_o = 1'b0;
    endtask
    // Null frame with the line left high
    task automatic send_stop();
        @(negedge clk_i);
        stop_o = 1'b1;
        @(negedge clk_i);
        stop_o = 1'b0;
    endtask
    // Holds the line low n cycles, notes any pull by the device
    task automatic pull_low(input int n, output logic pulled);
        pulled = 1'b0;
        @(negedge clk_i);
        line_low_o = 1'b1;
        out_frame_o = 1'b1;
        repeat (n) begin
            @(negedge clk_i);
            pulled = pulled | sio_oe_i;
        end
        line_low_o = 1'b0;
        out_frame_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Bench for the command decoder: opcode table, writes, busy, aborts
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WR = 50;
    localparam int DS = 8;
    localparam logic [2:0] SS = 3'h5;
    typedef struct packed {
        logic [3:0] op;
        logic [2:0] ss;
        logic rw, ack, std;
    } row_t;
    localparam row_t ROWS [11] = '{
        '{4'hA, SS, 1'b0, 1'b1, 1'b0},
        '{4'hB, SS, 1'b0, 1'b1, 1'b0},
        '{4'hA, 3'h2, 1'b0, 1'b0, 1'b0},
        '{4'h3, SS, 1'b0, 1'b0, 1'b0},
        '{4'hD, SS, 1'b1, 1'b0, 1'b0},
        '{4'hD, SS, 1'b0, 1'b1, 1'b1},
        '{4'hD, SS, 1'b1, 1'b1, 1'b1},
        '{4'hE, SS, 1'b1, 1'b0, 1'b1},
        '{4'hE, SS, 1'b0, 1'b1, 1'b0},
        '{4'hC, SS, 1'b1, 1'b1, 1'b0},
        '{4'h7, SS, 1'b1, 1'b1, 1'b0}
    };
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic mem_ready_i = 1'b1;
    logic start_i, bit_valid_i, bit_i, stop_i, out_frame_i, line_low_i;
    logic sio_o, sio_oe_o, busy_o, std_speed_o, sec_locked_o;
    logic zones_frozen_o, prog_abort_o, read_req_o, mem_valid_o;
    logic mem_region_o;
    logic [3:0] zone_ro_o, read_op_o;
    logic [6:0] read_addr_o, mem_addr_o;
    logic [7:0] mem_data_o;
    logic [15:0] wr_log[$];
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int reads = 0;
    always #2.5 clk_i = ~clk_i;
    cmd_write #(.WR_CYCLES(WR), .DSCHG_CYCLES(DS)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .slave_select_i(SS),
        .start_i(start_i), .bit_valid_i(bit_valid_i), .bit_i(bit_i),
        .stop_i(stop_i), .out_frame_i(out_frame_i),
        .line_low_i(line_low_i), .sio_o(sio_o), .sio_oe_o(sio_oe_o),
        .busy_o(busy_o), .std_speed_o(std_speed_o),
        .sec_locked_o(sec_locked_o), .zones_frozen_o(zones_frozen_o),
        .zone_ro_o(zone_ro_o), .prog_abort_o(prog_abort_o),
        .read_req_o(read_req_o), .read_op_o(read_op_o),
        .read_addr_o(read_addr_o), .mem_valid_o(mem_valid_o),
        .mem_ready_i(mem_ready_i), .mem_region_o(mem_region_o),
        .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o)
    );
    host_master i_host (
        .clk_i(clk_i), .sio_oe_i(sio_oe_o), .start_o(start_i),
        .bit_valid_o(bit_valid_i), .bit_o(bit_i), .stop_o(stop_i),
        .out_frame_o(out_frame_i), .line_low_o(line_low_i)
    );
    always @(posedge clk_i) begin
        if (mem_valid_o === 1'b1 && mem_ready_i) begin
            wr_log.push_back({mem_region_o, mem_addr_o, mem_data_o});
        end
        if (read_req_o === 1'b1) begin
            reads = reads + 1;
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            $display("BAD %0t run did not finish", $time);
            tally_and_finish();
        end
    end
    task automatic check(input logic [39:0] got, input logic [39:0] exp,
        input string what);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t %s: %0h not %0h", $time, what, got, exp);
        end
    endtask
    // Start, device byte, n < 0: no address, then n data bytes, stop
    task automatic cmd(input logic [3:0] op, input logic rw,
        input logic [2:0] ss, input logic [7:0] addr, input int n,
        input logic [7:0] d0, output logic [39:0] acks);
        logic a;
        acks = '0;
        i_host.send_start();
        i_host.send_bits({op, ss, rw}, 8);
        i_host.get_ack(a);
        acks[0] = a;
        for (int i = -1; i < n; i++) begin
            i_host.send_bits(i < 0 ? addr : d0 + 8'(i), 8);
            i_host.get_ack(a);
            acks[i + 2] = a;
        end
        i_host.send_stop();
    endtask
    task automatic wait_idle();
        repeat (4000) begin
            if (busy_o === 1'b1) @(negedge clk_i);
        end
    endtask
    initial begin
        logic [39:0] acks;
        logic [15:0] e;
        logic p;
        int c0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        check(40'({busy_o, std_speed_o, sec_locked_o, zones_frozen_o, sio_o,
            zone_ro_o, prog_abort_o, mem_valid_o, sio_oe_o}), 40'h0, "reset");
        foreach (ROWS[k]) begin
            cmd(ROWS[k].op, ROWS[k].rw, ROWS[k].ss, 8'h00, -1, 8'h00, acks);
            check(40'(acks[0]), 40'(ROWS[k].ack), "opcode ack");
            check(40'(std_speed_o), 40'(ROWS[k].std), "speed");
            check(40'(busy_o), 40'h0, "back to idle");
        end
        check(40'(reads), 40'h2, "read requests");
        check(40'(read_op_o), 40'(ROWS[10].op), "read opcode");
        cmd(4'hA, 1'b0, SS, 8'h85, 1, 8'h3C, acks);
        check(acks, 40'h7, "byte write acks");
        check(40'(busy_o), 40'h1, "cycle started");
        check(40'(read_addr_o), 40'h06, "address step");
        c0 = cycles;
        i_host.pull_low(2, p);
        check(40'(p), 40'h0, "short pulse");
        cmd(4'hA, 1'b0, SS, 8'h01, 0, 8'h00, acks);
        check(acks, 40'h0, "ignored while busy");
        wait_idle();
        c0 = cycles - c0;
        check(40'(c0 >= WR - 4 && c0 <= WR + 6), 40'h1, "cycle time");
        check(40'(wr_log.size()), 40'h1, "one word");
        check(40'(wr_log[0]), 40'({1'b0, 7'h05, 8'h3C}), "top bit");
        wr_log.delete();
        mem_ready_i = 1'b0;
        cmd(4'hA, 1'b0, SS, 8'h0E, 10, 8'h50, acks);
        check(acks, 40'hFFF, "page acks");
        repeat (WR + 20) @(negedge clk_i);
        check(40'(busy_o), 40'h1, "stall holds busy");
        mem_ready_i = 1'b1;
        wait_idle();
        check(40'(wr_log.size()), 40'hA, "page words");
        for (int i = 0; i < 10; i++) begin
            e = {1'b0, 4'h1, 3'(6 + i), 8'h50 + 8'(i)};
            check(40'(wr_log[i]), 40'(e), "wrap");
        end
        wr_log.delete();
        mem_ready_i = 1'b0;
        cmd(4'hA, 1'b0, SS, 8'h00, 33, 8'h00, acks);
        check(acks, 40'h3_FFFF_FFFF, "full buffer refuses");
        mem_ready_i = 1'b1;
        wait_idle();
        wr_log.delete();
        i_host.send_start();
        i_host.send_bits({4'hA, SS, 1'b0}, 8);
        i_host.get_ack(p);
        i_host.send_bits(8'h10, 8);
        i_host.get_ack(p);
        i_host.send_bits(8'hA5, 8);
        i_host.get_ack(p);
        i_host.send_bits(8'h5A, 4);
        i_host.send_stop();
        repeat (4) @(negedge clk_i);
        check(40'({busy_o, mem_valid_o}), 40'h0, "partial byte");
        cmd(4'hB, 1'b0, SS, 8'h03, 1, 8'h11, acks);
        check(acks, 40'h3, "secure low part");
        cmd(4'hB, 1'b0, SS, 8'h12, 1, 8'h77, acks);
        check(acks, 40'h7, "secure user part");
        wait_idle();
        check(40'(wr_log[0]), 40'({1'b1, 7'h12, 8'h77}), "secure word");
        cmd(4'h2, 1'b0, SS, 8'h60, 1, 8'h00, acks);
        check(acks, 40'h7, "lock acks");
        i_host.pull_low(DS + 2, p);
        repeat (2) @(negedge clk_i);
        check(40'({busy_o, prog_abort_o, sec_locked_o}), 40'h2, "end");
        cmd(4'h2, 1'b0, SS, 8'h60, 1, 8'h00, acks);
        check(40'(prog_abort_o), 40'h0, "abort flag cleared");
        wait_idle();
        check(40'(sec_locked_o), 40'h1, "locked");
        cmd(4'h2, 1'b0, SS, 8'h60, 0, 8'h00, acks);
        check(acks, 40'h1, "check lock");
        cmd(4'hB, 1'b0, SS, 8'h12, 1, 8'h77, acks);
        check(acks, 40'h3, "locked secure");
        cmd(4'h7, 1'b0, SS, 8'h01, 1, 8'hFF, acks);
        wait_idle();
        check(40'(zone_ro_o), 40'h2, "zone set");
        cmd(4'hA, 1'b0, SS, 8'h20, 1, 8'h01, acks);
        check(acks, 40'h3, "read-only zone");
        cmd(4'h1, 1'b0, SS, 8'h00, 1, 8'h00, acks);
        wait_idle();
        check(40'(zones_frozen_o), 40'h1, "frozen");
        cmd(4'h7, 1'b0, SS, 8'h02, 1, 8'hFF, acks);
        wait_idle();
        check(40'(zone_ro_o), 40'h2, "zones kept");
        rst_i = 1'b1;
        @(negedge clk_i);
        rst_i = 1'b0;
        check(40'({busy_o, sec_locked_o, zones_frozen_o, zone_ro_o}), 40'h0,
            "second reset");
        cmd(4'h2, 1'b0, SS, 8'h60, 0, 8'h00, acks);
        check(acks, 40'h3, "lock state after reset");
        tally_and_finish();
    end
endmodule
`default_nettype wire
